// ---- dv/aab_exec_asserts.sv ----
// Checker of datapath outputs against the operations that cause them
// Assumes binding to the datapath top; one clock domain
`include "aab_cfg.svh"
module aab_exec_asserts
   import aab_pkg::*;
(
   // Clock and reset
   input logic I_MCLK,
   input logic I_SYS_RST,
   // Operation
   input aab_op_t i_op,
   input logic [7:0] i_literal,
   input logic [2:0] i_bit_sel,
   // Results and pulses
   input logic [7:0] O_ACC,
   input logic O_CARRY,
   input logic O_FILE_WE,
   input logic [6:0] O_FILE_WADDR,
   input logic [7:0] O_FILE_WDATA,
   input logic O_PRESCALER_CLR,
   input logic O_FLUSH_NEXT,
   input logic O_CYCLE_DONE
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);
   // Write-back edge of an operation that was not flushed
   sequence s_commit(aab_op_t op); O_CYCLE_DONE && !$past(O_FLUSH_NEXT, 4) && $past(i_op) == op; endsequence
   property p_done; O_CYCLE_DONE |=> !O_CYCLE_DONE [*3] ##1 O_CYCLE_DONE; endproperty
   a_done: assert property (p_done) else $error("done spacing");
   property p_flush; O_FLUSH_NEXT |-> ##4 O_CYCLE_DONE && !O_FILE_WE && !O_FLUSH_NEXT; endproperty
   a_flush: assert property (p_flush) else $error("flush cycle acted");
   property p_branch; s_commit(AAB_OP_BRANCH) |-> O_FLUSH_NEXT; endproperty
   a_branch: assert property (p_branch) else $error("branch single cycle");
   property p_tmr; O_PRESCALER_CLR |-> O_FILE_WE && O_FILE_WADDR == `AAB_TMR_ADDR; endproperty
   a_tmr: assert property (p_tmr) else $error("stray prescaler clear");
   property p_add;
      s_commit(AAB_OP_ADD_LIT) |-> {O_CARRY, O_ACC} == {1'b0, $past(O_ACC, 2)} + {1'b0, $past(i_literal)};
   endproperty
   a_add: assert property (p_add) else $error("literal add");
   property p_and;
      s_commit(AAB_OP_AND_LIT) |-> O_ACC == ($past(O_ACC, 2) & $past(i_literal)) && O_CARRY == $past(O_CARRY, 2);
   endproperty
   a_and: assert property (p_and) else $error("literal and");
   property p_set;
      s_commit(AAB_OP_BIT_SET) |-> O_FILE_WE && O_FILE_WDATA[$past(i_bit_sel)] && O_ACC == $past(O_ACC, 2);
   endproperty
   a_set: assert property (p_set) else $error("bit set");
   property p_clr;
      s_commit(AAB_OP_BIT_CLR) |-> O_FILE_WE && !O_FILE_WDATA[$past(i_bit_sel)] && O_CARRY == $past(O_CARRY, 2);
   endproperty
   a_clr: assert property (p_clr) else $error("bit clear");
endmodule

// ---- dv/tb_aab_exec.sv ----
// Self-checking bench of the execution datapath, corner and random operations
// Assumes package, constants header and checker are compiled before it
`include "aab_cfg.svh"
module tb_aab_exec
   import aab_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic I_MCLK = 1'b0, I_SYS_RST = 1'b1, i_dest_file = 1'b0, i_psa_to_wdt = 1'b0;
   aab_op_t i_op = AAB_OP_NOP;
   logic [7:0] i_literal = 8'h00, i_file_rdata = 8'h00, i_port_a_pins = 8'h00, i_port_b_pins = 8'h00;
   logic [6:0] i_file_addr = 7'h00, O_FILE_WADDR;
   logic [2:0] i_bit_sel = 3'h0;
   logic [7:0] O_ACC, O_FILE_WDATA, w = 8'h00;
   logic O_CARRY, O_DIGIT_CARRY_FLAG, O_ZERO, O_FILE_WE, O_PRESCALER_CLR, O_FLUSH_NEXT, O_CYCLE_DONE;
   logic mc = 1'b0, mdc = 1'b0, mz = 1'b0, fpend = 1'b0;
   int errors = 0, check_count = 0, seed = 38820;
   aab_exec uut (
      .I_MCLK(I_MCLK),
      .I_SYS_RST(I_SYS_RST),
      .i_op(i_op),
      .i_literal(i_literal),
      .i_file_addr(i_file_addr),
      .i_bit_sel(i_bit_sel),
      .i_dest_file(i_dest_file),
      .i_file_rdata(i_file_rdata),
      .i_port_a_pins(i_port_a_pins),
      .i_port_b_pins(i_port_b_pins),
      .i_psa_to_wdt(i_psa_to_wdt),
      .O_ACC(O_ACC),
      .O_CARRY(O_CARRY),
      .O_DIGIT_CARRY_FLAG(O_DIGIT_CARRY_FLAG),
      .O_ZERO(O_ZERO),
      .O_FILE_WE(O_FILE_WE),
      .O_FILE_WADDR(O_FILE_WADDR),
      .O_FILE_WDATA(O_FILE_WDATA),
      .O_PRESCALER_CLR(O_PRESCALER_CLR),
      .O_FLUSH_NEXT(O_FLUSH_NEXT),
      .O_CYCLE_DONE(O_CYCLE_DONE)
   );
   task automatic compare_pulses(input logic [3:0] got, exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t pulses got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic compare_write(input logic [14:0] got, exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t file write got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic compare_acc(input logic [10:0] got, exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t acc and flags got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Source operand as the datapath must see it: pins for port addresses
   function automatic logic [7:0] exp_src(input logic [6:0] f, input logic [24:0] rv);
      if (f == `AAB_PORTA_ADDR) return rv[15:8];
      if (f == `AAB_IO_PORT_TWO_ADDR) return rv[7:0];
      return rv[23:16];
   endfunction
   // One instruction cycle: drive at its first edge, check its results after its fourth
   task automatic run(input aab_op_t o, input logic [7:0] k, input logic [6:0] f, input logic [2:0] b, input logic dd);
      logic [7:0] src, res, opnd;
      logic [24:0] rv;
      logic ewe, epc, efl;
      rv = 25'($random(seed));
      @(posedge I_MCLK);
      i_op <= o;
      i_literal <= k;
      i_file_addr <= f;
      i_bit_sel <= b;
      i_dest_file <= dd;
      {i_psa_to_wdt, i_file_rdata, i_port_a_pins, i_port_b_pins} <= rv;
      #1;
      compare_pulses({O_FILE_WE, O_PRESCALER_CLR, O_FLUSH_NEXT, O_CYCLE_DONE}, 4'h0);
      src = exp_src(f, rv);
      opnd = (o inside {AAB_OP_ADD_LIT, AAB_OP_AND_LIT}) ? k : src;
      res = src;
      {ewe, efl} = 2'b00;
      if (fpend) fpend = 1'b0;
      else begin
         case (o)
            AAB_OP_ADD_LIT, AAB_OP_ADD_FILE: {mc, res} = {1'b0, w} + {1'b0, opnd};
            AAB_OP_AND_LIT, AAB_OP_AND_FILE: res = w & opnd;
            AAB_OP_BIT_CLR, AAB_OP_BIT_SET: res[b] = (o == AAB_OP_BIT_SET);
            AAB_OP_BIT_SKIP: efl = src[b];
            AAB_OP_BRANCH: efl = 1'b1;
            default: ;
         endcase
         if (o inside {[AAB_OP_ADD_LIT:AAB_OP_ADD_FILE]}) mdc = ({1'b0, w[3:0]} + {1'b0, opnd[3:0]}) > 5'h0f;
         if (o inside {[AAB_OP_ADD_LIT:AAB_OP_AND_FILE]}) mz = (res == 8'h00);
         ewe = (o inside {AAB_OP_BIT_CLR, AAB_OP_BIT_SET}) || (dd && o inside {AAB_OP_ADD_FILE, AAB_OP_AND_FILE});
         if (!ewe && o inside {[AAB_OP_ADD_LIT:AAB_OP_AND_FILE]}) w = res;
         fpend = efl;
      end
      epc = ewe && (f == `AAB_TMR_ADDR) && !rv[24];
      repeat (3) @(posedge I_MCLK);
      #1;
      compare_pulses({O_FILE_WE, O_PRESCALER_CLR, O_FLUSH_NEXT, O_CYCLE_DONE}, {ewe, epc, efl, 1'b1});
      if (ewe) compare_write({O_FILE_WADDR, O_FILE_WDATA}, {f, res});
      compare_acc({O_CARRY, O_DIGIT_CARRY_FLAG, O_ZERO, O_ACC}, {mc, mdc, mz, w});
   endtask
   initial begin
      forever #20 I_MCLK = ~I_MCLK;
   end
   // About three times the length of the whole sequence
   initial begin
      #200000;
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge I_MCLK);
      I_SYS_RST <= 1'b0;
      run(AAB_OP_AND_LIT, 8'h00, 7'h00, 3'h0, 1'b0);
      run(AAB_OP_ADD_LIT, 8'hff, 7'h00, 3'h0, 1'b0);
      run(AAB_OP_ADD_LIT, 8'h01, 7'h00, 3'h0, 1'b0);
      run(AAB_OP_BRANCH, 8'h00, 7'h00, 3'h0, 1'b0);
      run(AAB_OP_BRANCH, 8'h00, 7'h00, 3'h0, 1'b0);
      run(AAB_OP_BIT_SET, 8'h00, `AAB_TMR_ADDR, 3'h7, 1'b0);
      run(AAB_OP_BIT_SKIP, 8'h00, `AAB_IO_PORT_TWO_ADDR, 3'h0, 1'b0);
      for (int i = 0; i < 400; i++) begin
         run(aab_op_t'($unsigned($random(seed)) % 9), 8'($random(seed)),
            (i % 3 == 0) ? 7'(i % 8) : 7'($random(seed)), 3'($random(seed)), 1'($random(seed)));
      end
      run(AAB_OP_NOP, 8'h00, 7'h00, 3'h0, 1'b0);
      report_and_stop();
   end
endmodule
bind aab_exec aab_exec_asserts u_chk (
   .I_MCLK(I_MCLK),
   .I_SYS_RST(I_SYS_RST),
   .i_op(i_op),
   .i_literal(i_literal),
   .i_bit_sel(i_bit_sel),
   .O_ACC(O_ACC),
   .O_CARRY(O_CARRY),
   .O_FILE_WE(O_FILE_WE),
   .O_FILE_WADDR(O_FILE_WADDR),
   .O_FILE_WDATA(O_FILE_WDATA),
   .O_PRESCALER_CLR(O_PRESCALER_CLR),
   .O_FLUSH_NEXT(O_FLUSH_NEXT),
   .O_CYCLE_DONE(O_CYCLE_DONE)
);

// ---- hw/aab_cfg.svh ----
// Constants of the accumulator ALU and bit operation datapath
// Assumes inclusion by the design modules, the checker and the bench
`ifndef AAB_CFG_SVH
`define AAB_CFG_SVH
`define AAB_PHASES 4
`define AAB_W_RST 8'h00
`define AAB_FLAG_RST 3'h0
`define AAB_FLAG_C 0
`define AAB_FLAG_DC 1
`define AAB_FLAG_Z 2
`define AAB_TMR_ADDR 7'h01
`define AAB_PORTA_ADDR 7'h05
`define AAB_IO_PORT_TWO_ADDR 7'h06
`endif

// ---- hw/aab_exec.sv ----
// Execution datapath: literal and file add/and, bit clear/set, bit test skip
// Assumes a decoder presents one operation per instruction cycle, held stable
// for all four phases, and file memory read data valid in the same cycle.
// Operation
// - Port read-modify-write sources come from pins
// - Writing timer counter clears assigned prescaler
// - Branch or true skip takes two cycles
// - Literal add updates acc, C, DC, Z
// - File add to selected destination, flags
// - Destination bit zero acc, one file
// - Literal AND updates acc, Z only
// - File AND to destination, Z only
// - Bit clear, other bits, flags unchanged
// - Bit set, other bits, flags unchanged
// - Bit one skips next as no-operation
// - Instruction cycle is four oscillator periods
`include "aab_cfg.svh"
module aab_exec
   import aab_pkg::*;
(
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   // Decoded instruction
   input wire aab_op_t i_op,
   input wire logic [7:0] i_literal,
   input wire logic [6:0] i_file_addr,
   input wire logic [2:0] i_bit_sel,
   input wire logic i_dest_file,
   // File memory and pins
   input wire logic [7:0] i_file_rdata,
   input wire logic [7:0] i_port_a_pins,
   input wire logic [7:0] i_port_b_pins,
   input wire logic i_psa_to_wdt,
   // Results
   output logic [7:0] O_ACC,
   output logic O_CARRY,
   output logic O_DIGIT_CARRY_FLAG,
   output logic O_ZERO,
   output logic O_FILE_WE,
   output logic [6:0] O_FILE_WADDR,
   output logic [7:0] O_FILE_WDATA,
   output logic O_PRESCALER_CLR,
   output logic O_FLUSH_NEXT,
   output logic O_CYCLE_DONE
);
   logic [7:0] acc_reg;
   logic [2:0] flag_reg;
   logic file_we_reg;
   logic [6:0] file_waddr_reg;
   logic [7:0] file_wdata_reg;
   logic psc_clr_reg;
   logic flush_reg;
   logic done_reg;
   aab_state_t state_reg;
   logic cycle_end;
   logic commit;
   logic writes_acc;
   logic [7:0] pa_s1_reg, pa_s2_reg, pb_s1_reg, pb_s2_reg;
   logic [7:0] src;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] result;
   logic [7:0] operand;
   logic [7:0] bit_mask;
   logic take_two;
   logic writes_file;

   function automatic logic [7:0] onehot8(input logic [2:0] b);
      onehot8 = 8'h01 << b;
   endfunction

   // Adds and ANDs share operand selection, flag updates and destination select
   function automatic logic is_add(input aab_op_t op);
      is_add = (op == AAB_OP_ADD_LIT) || (op == AAB_OP_ADD_FILE);
   endfunction

   function automatic logic is_and(input aab_op_t op);
      is_and = (op == AAB_OP_AND_LIT) || (op == AAB_OP_AND_FILE);
   endfunction

   function automatic logic is_lit(input aab_op_t op);
      is_lit = (op == AAB_OP_ADD_LIT) || (op == AAB_OP_AND_LIT);
   endfunction

   function automatic logic is_file_alu(input aab_op_t op);
      is_file_alu = (op == AAB_OP_ADD_FILE) || (op == AAB_OP_AND_FILE);
   endfunction

   aab_phase_gen u_phase (
      .i_clk(I_MCLK),
      .i_rst(I_SYS_RST),
      .o_phase(),
      .o_cycle_end(cycle_end)
   );

   // Pin synchronisers; only the second stage is read
   always_ff @(posedge I_MCLK) begin
      pa_s1_reg <= i_port_a_pins;
      pa_s2_reg <= pa_s1_reg;
      pb_s1_reg <= i_port_b_pins;
      pb_s2_reg <= pb_s1_reg;
   end

   // Port addresses read the pins, not the output latch, so a read-modify-write
   // writes back what the pins really show
   always_comb begin
      if (i_file_addr == `AAB_PORTA_ADDR) begin
         src = pa_s2_reg;
      end else if (i_file_addr == `AAB_IO_PORT_TWO_ADDR) begin
         src = pb_s2_reg;
      end else begin
         src = i_file_rdata;
      end
   end

   assign operand = is_lit(i_op) ? i_literal : src;
   assign sum = {1'b0, acc_reg} + {1'b0, operand};
   assign low_sum = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]};
   assign bit_mask = onehot8(i_bit_sel);

   always_comb begin
      result = 8'h00;
      unique case (i_op)
         AAB_OP_ADD_LIT, AAB_OP_ADD_FILE: result = sum[7:0];
         AAB_OP_AND_LIT, AAB_OP_AND_FILE: result = acc_reg & operand;
         AAB_OP_BIT_CLR: result = src & ~bit_mask;
         AAB_OP_BIT_SET: result = src | bit_mask;
         AAB_OP_NOP, AAB_OP_BIT_SKIP, AAB_OP_BRANCH: result = 8'h00;
         default: result = 8'h00;
      endcase
   end

   assign writes_file = (is_file_alu(i_op) && i_dest_file)
      || (i_op == AAB_OP_BIT_CLR) || (i_op == AAB_OP_BIT_SET);
   assign writes_acc = is_lit(i_op) || (is_file_alu(i_op) && !i_dest_file);
   assign commit = cycle_end && (state_reg == AAB_ST_EXEC);
   assign take_two = (i_op == AAB_OP_BRANCH)
      || ((i_op == AAB_OP_BIT_SKIP) && ((src & bit_mask) != 8'h00));

   // Sequencer: second cycle of a two-cycle instruction is a no-operation
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         state_reg <= AAB_ST_EXEC;
      end else if (cycle_end) begin
         unique case (state_reg)
            AAB_ST_EXEC: state_reg <= take_two ? AAB_ST_FLUSH : AAB_ST_EXEC;
            AAB_ST_FLUSH: state_reg <= AAB_ST_EXEC;
         endcase
      end
   end

   // Working register: written only by an executing cycle, never by a flush cycle
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         acc_reg <= `AAB_W_RST;
      end else if (commit && writes_acc) begin
         acc_reg <= result;
      end
   end

   // Flags: adds update all three, ANDs only zero, bit operations none
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         flag_reg <= `AAB_FLAG_RST;
      end else if (commit) begin
         if (is_add(i_op)) begin
            flag_reg[`AAB_FLAG_C] <= sum[8];
            flag_reg[`AAB_FLAG_DC] <= low_sum[4];
            flag_reg[`AAB_FLAG_Z] <= (result == 8'h00);
         end
         if (is_and(i_op)) begin
            flag_reg[`AAB_FLAG_Z] <= (result == 8'h00);
         end
      end
   end

   // File write port; address and data are valid while the strobe is high
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         file_we_reg <= 1'b0;
         file_waddr_reg <= 7'h00;
         file_wdata_reg <= 8'h00;
      end else begin
         file_we_reg <= commit && writes_file;
         file_waddr_reg <= i_file_addr;
         file_wdata_reg <= result;
      end
   end

   // Any write to the timer counter clears the prescaler while the timer owns it
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         psc_clr_reg <= 1'b0;
      end else begin
         psc_clr_reg <= commit && writes_file && (i_file_addr == `AAB_TMR_ADDR) && !i_psa_to_wdt;
      end
   end

   // Tells the fetch side to discard the next instruction
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         flush_reg <= 1'b0;
      end else begin
         flush_reg <= commit && take_two;
      end
   end

   // One pulse per instruction cycle, flush cycles included
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= cycle_end;
      end
   end

   // Outputs are the registers themselves
   assign O_ACC = acc_reg;
   assign O_CARRY = flag_reg[`AAB_FLAG_C];
   assign O_DIGIT_CARRY_FLAG = flag_reg[`AAB_FLAG_DC];
   assign O_ZERO = flag_reg[`AAB_FLAG_Z];
   assign O_FILE_WE = file_we_reg;
   assign O_FILE_WADDR = file_waddr_reg;
   assign O_FILE_WDATA = file_wdata_reg;
   assign O_PRESCALER_CLR = psc_clr_reg;
   assign O_FLUSH_NEXT = flush_reg;
   assign O_CYCLE_DONE = done_reg;
endmodule

// ---- hw/aab_phase_gen.sv ----
// Four-phase instruction cycle sequencer
// Assumes one oscillator period per clock edge
`include "aab_cfg.svh"
module aab_phase_gen
   import aab_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   output logic [1:0] o_phase,
   output logic o_cycle_end
);
   logic [1:0] phase_reg;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end
   assign o_phase = phase_reg;
   assign o_cycle_end = (phase_reg == 2'(`AAB_PHASES - 1));
endmodule

// ---- hw/aab_pkg.sv ----
// Types of the accumulator ALU and bit operation datapath
// Assumes the constants header is on the include path
package aab_pkg;
   typedef enum logic [3:0] {
      AAB_OP_NOP,
      AAB_OP_ADD_LIT,
      AAB_OP_ADD_FILE,
      AAB_OP_AND_LIT,
      AAB_OP_AND_FILE,
      AAB_OP_BIT_CLR,
      AAB_OP_BIT_SET,
      AAB_OP_BIT_SKIP,
      AAB_OP_BRANCH
   } aab_op_t;
   typedef enum logic {
      AAB_ST_EXEC,
      AAB_ST_FLUSH
   } aab_state_t;
endpackage
